// *** shared/tmr_cmp_dt_pkg.sv ***
// Shared constants and carriers for the compare-five / dead-time / readback register block.
// Assumes one timer clock; every user of these names writes tmr_cmp_dt_pkg::name.
package tmr_cmp_dt_pkg;

    // ************************************************************
    // Register word indexes (byte address is four times the index)
    // ************************************************************
    localparam logic [31:0] IDX_DEAD_TIME_VALUE_ZERO  = 32'h0FFFF58E;
    localparam logic [31:0] IDX_COMPARE_VALUE_FIVE    = 32'h0FFFF590;
    localparam logic [31:0] IDX_MAIN_COUNTER_READBACK = 32'hFFFFF5A6;
    localparam logic [31:0] IDX_SUB_COUNTER_READBACK  = 32'hFFFFF5A8;
    localparam logic [31:0] IDX_DEAD_TIME_ZERO_ALIAS  = 32'hFFFFFB44;
    localparam logic [31:0] IDX_COMPARE_FIVE_ALIAS    = 32'hFFFFFB46;
    localparam logic [31:0] IDX_COMPARE_CONTROL       = 32'hFFFFFB60;

    // ************************************************************
    // Field layouts and reset values
    // ************************************************************
    localparam int          DT_MSB            = 9;
    localparam int          DT_LSB            = 1;
    localparam logic [15:0] DT_FIELD_MASK     = 16'h03FE;
    localparam logic [15:0] RESET_VALUE       = 16'h0000;
    localparam logic [15:0] IDLE_COUNT        = 16'hFFFF;
    localparam logic [15:0] IDLE_COUNT_HA     = 16'hFFFE;
    localparam logic [15:0] LSB_CLEAR_MASK    = 16'hFFFE;
    localparam int          CTL_IMMEDIATE_BIT = 0;
    localparam int          CTL_ADC_SEL_BIT   = 1;
    localparam logic [1:0]  CTL_RESET         = 2'h0;
    localparam logic [1:0]  FULL_HALFWORD     = 2'h3;

    // ************************************************************
    // Operating modes of the timer
    // ************************************************************
    typedef enum logic [3:0] {
        MODE_INTERVAL     = 4'h0,
        MODE_EXT_EVENT    = 4'h1,
        MODE_FREE_RUN     = 4'h2,
        MODE_ONE_SHOT     = 4'h3,
        MODE_PWM          = 4'h4,
        MODE_EXT_TRIGGER  = 4'h5,
        MODE_TRI_PWM      = 4'h6,
        MODE_HA_TRI_PWM   = 4'h7,
        MODE_DT_PWM       = 4'h8,
        MODE_EXC_120      = 4'h9,
        MODE_SPECIAL_120  = 4'hA,
        MODE_SPECIAL_PATT = 4'hB
    } timer_mode_e;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        timer_mode_e mode;
        logic        timer_run_bit;
        logic        dead_time_select_bit;
        logic        counting;
        logic        reload_point;
        logic [15:0] main_count;
        logic [15:0] sub_count;
    } timer_state_s;

    typedef struct packed {
        logic [15:0] dead_time;
        logic        dead_time_run;
        logic        dead_time_insert;
        logic [15:0] compare_active;
    } dead_time_out_s;

endpackage

// *** hw/tmr_cmp_dt_regs.sv ***
// Compare-five, dead-time-zero and counter readback registers behind an APB slave.
// Assumes the rest of the timer supplies mode, run bit, counters and reload points on clk_i.
`timescale 1ns/1ps

// Notes on behaviour
// - Compare-five alias reaches same value.
// - Compare-five match can trigger A/D.
// - These registers use whole 16-bit accesses.
// - Any reset zeroes compare and dead-time.
// - High-accuracy mode ignores compare bit zero.
// - Reload-type modes apply writes at reload.
// - Simple counting modes apply writes immediately.
// - High-accuracy mode selects reload or immediate.
// - Counter readbacks are read-only 16-bit.
// - Readbacks zero on reset or stop.
// - Before counting, main readback shows ones.
// - High-accuracy mode reads bit zero zero.
// - Sub-counter works only in two modes.
// - Dead-time value bits nine to one.
// - Dead-time counter runs in listed modes.
// - Zero dead-time inserts no dead time.
// - Dead-time alias reaches same value.
module tmr_cmp_dt_regs
(
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           psel_i,
    input  wire logic                           penable_i,
    input  wire logic                           pwrite_i,
    input  wire logic [31:0]                    paddr_i,
    input  wire logic [31:0]                    pwdata_i,
    input  wire logic [3:0]                     pstrb_i,
    output logic      [31:0]                    prdata_o,
    output logic                                pready_o,
    output logic                                pslverr_o,
    input  wire tmr_cmp_dt_pkg::timer_state_s   timer_i,
    output tmr_cmp_dt_pkg::dead_time_out_s      dead_time_o,
    output logic                                adc_trigger_o
);

    // ************************************************************
    // Mode decode
    // ************************************************************
    logic ha_mode;
    logic reload_mode;
    logic adc_capable;
    logic sub_capable;
    logic dt_capable;

    // Mode classes used by the write policy, trigger and counters
    always_comb
    begin
        ha_mode     = (timer_i.mode == tmr_cmp_dt_pkg::MODE_HA_TRI_PWM);
        reload_mode = 1'b0;
        adc_capable = 1'b0;
        sub_capable = 1'b0;
        dt_capable  = 1'b0;
        unique case (timer_i.mode)
            tmr_cmp_dt_pkg::MODE_PWM:
            begin
                reload_mode = 1'b1;
                dt_capable  = timer_i.dead_time_select_bit;
            end
            tmr_cmp_dt_pkg::MODE_EXT_TRIGGER,
            tmr_cmp_dt_pkg::MODE_TRI_PWM:
            begin
                reload_mode = 1'b1;
            end
            tmr_cmp_dt_pkg::MODE_HA_TRI_PWM:
            begin
                adc_capable = 1'b1;
                sub_capable = 1'b1;
                dt_capable  = 1'b1;
            end
            tmr_cmp_dt_pkg::MODE_DT_PWM:
            begin
                reload_mode = 1'b1;
                adc_capable = 1'b1;
                sub_capable = 1'b1;
                dt_capable  = 1'b1;
            end
            tmr_cmp_dt_pkg::MODE_EXC_120:
            begin
                reload_mode = 1'b1;
                dt_capable  = 1'b1;
            end
            tmr_cmp_dt_pkg::MODE_SPECIAL_120:
            begin
                reload_mode = 1'b1;
                adc_capable = 1'b1;
                dt_capable  = 1'b1;
            end
            tmr_cmp_dt_pkg::MODE_SPECIAL_PATT:
            begin
                reload_mode = 1'b1;
                adc_capable = 1'b1;
                dt_capable  = timer_i.dead_time_select_bit;
            end
            default:
            begin
                // Free-running, event count, one-shot and interval keep defaults
                reload_mode = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // APB decode
    // ************************************************************
    logic        access;
    logic        commit;
    logic        full_half;
    logic        hit_cmp;
    logic        hit_dt;
    logic        hit_main;
    logic        hit_sub;
    logic        hit_ctl;
    logic        bad_access;
    logic [15:0] wr_half;

    // Word index compare on the upper address bits
    // Byte lanes inside the word are not decoded; strobes judge partial writes
    always_comb
    begin
        access    = psel_i & penable_i & ~pready_o;
        commit    = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
        full_half = (pstrb_i[1:0] == tmr_cmp_dt_pkg::FULL_HALFWORD);
        wr_half   = pwdata_i[15:0];
        hit_cmp   = (paddr_i[31:2] == tmr_cmp_dt_pkg::IDX_COMPARE_VALUE_FIVE[29:0])
                  | (paddr_i[31:2] == tmr_cmp_dt_pkg::IDX_COMPARE_FIVE_ALIAS[29:0]);
        hit_dt    = (paddr_i[31:2] == tmr_cmp_dt_pkg::IDX_DEAD_TIME_VALUE_ZERO[29:0])
                  | (paddr_i[31:2] == tmr_cmp_dt_pkg::IDX_DEAD_TIME_ZERO_ALIAS[29:0]);
        hit_main  = (paddr_i[31:2] == tmr_cmp_dt_pkg::IDX_MAIN_COUNTER_READBACK[29:0]);
        hit_sub   = (paddr_i[31:2] == tmr_cmp_dt_pkg::IDX_SUB_COUNTER_READBACK[29:0]);
        hit_ctl   = (paddr_i[31:2] == tmr_cmp_dt_pkg::IDX_COMPARE_CONTROL[29:0]);
        // Partial compare and dead-time writes and writes to readbacks are refused, not merged
        bad_access = ~(hit_cmp | hit_dt | hit_main | hit_sub | hit_ctl)
                   | (pwrite_i & ~full_half & (hit_cmp | hit_dt))
                   | (pwrite_i & (hit_main | hit_sub));
    end

    // ************************************************************
    // Registers written by software
    // ************************************************************
    logic [15:0] compare_buffer;
    logic [15:0] compare_active;
    logic [15:0] dead_time;
    logic [1:0]  control;
    logic        write_now;

    // Immediate rewrite when stopped, in simple modes, or when selected in high-accuracy mode
    // A write while stopped must reach the comparator, or the first period
    // after start would run on a stale value
    always_comb
    begin
        write_now = ~timer_i.timer_run_bit
                  | ~(reload_mode | ha_mode)
                  | (ha_mode & control[tmr_cmp_dt_pkg::CTL_IMMEDIATE_BIT]);
    end

    // Compare value seen by software; both addresses land here
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            compare_buffer <= tmr_cmp_dt_pkg::RESET_VALUE;
        end
        else if (commit & hit_cmp)
        begin
            compare_buffer <= wr_half;
        end
    end

    // Compare value used by the comparator; an immediate write in the reload edge's cycle wins
    // Limitation: a second write before the reload replaces the pending value
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            compare_active <= tmr_cmp_dt_pkg::RESET_VALUE;
        end
        else if (commit & hit_cmp & write_now)
        begin
            compare_active <= wr_half;
        end
        else if (timer_i.reload_point)
        begin
            compare_active <= compare_buffer;
        end
    end

    // Dead-time value; only bits nine to one are stored
    // Dropping the fixed bits here means reads need no masking later
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dead_time <= tmr_cmp_dt_pkg::RESET_VALUE;
        end
        else if (commit & hit_dt)
        begin
            dead_time <= wr_half & tmr_cmp_dt_pkg::DT_FIELD_MASK;
        end
    end

    // Control bits: rewrite method select and A/D trigger select
    // Only byte lane zero carries them; other lanes are ignored
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            control <= tmr_cmp_dt_pkg::CTL_RESET;
        end
        else if (commit & hit_ctl & pstrb_i[0])
        begin
            control <= pwdata_i[1:0];
        end
    end

    // ************************************************************
    // Counter readbacks
    // ************************************************************
    logic [15:0] main_readback;
    logic [15:0] sub_readback;
    logic [15:0] lsb_mask;

    // High-accuracy mode hides bit zero of both readbacks
    always_comb
    begin
        lsb_mask = ha_mode ? tmr_cmp_dt_pkg::LSB_CLEAR_MASK : 16'hFFFF;
    end

    // Main readback: zero when stopped, idle pattern until counting begins
    // Registered, so a read sees the count one clock old; this keeps
    // the read mux shallow at the cost of a lag software cannot resolve
    always_ff @(posedge clk_i)
    begin
        if (rst_i | ~timer_i.timer_run_bit)
        begin
            main_readback <= tmr_cmp_dt_pkg::RESET_VALUE;
        end
        else if (~timer_i.counting)
        begin
            main_readback <= ha_mode ? tmr_cmp_dt_pkg::IDLE_COUNT_HA
                                     : tmr_cmp_dt_pkg::IDLE_COUNT;
        end
        else
        begin
            main_readback <= timer_i.main_count & lsb_mask;
        end
    end

    // Sub readback follows the sub-counter only where it exists
    // Outside its two modes the sub-counter input is not trusted, so show zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i | ~timer_i.timer_run_bit)
        begin
            sub_readback <= tmr_cmp_dt_pkg::RESET_VALUE;
        end
        else if (sub_capable & timer_i.counting)
        begin
            sub_readback <= timer_i.sub_count & lsb_mask;
        end
        else
        begin
            sub_readback <= tmr_cmp_dt_pkg::RESET_VALUE;
        end
    end

    // ************************************************************
    // APB answer: one wait state, then pready for one cycle
    // ************************************************************
    logic [31:0] next_rdata;

    // Read mux; upper half always zero
    always_comb
    begin
        next_rdata = 32'h00000000;
        if (hit_cmp)
        begin
            next_rdata[15:0] = compare_buffer;
        end
        else if (hit_dt)
        begin
            next_rdata[15:0] = dead_time;
        end
        else if (hit_main)
        begin
            next_rdata[15:0] = main_readback;
        end
        else if (hit_sub)
        begin
            next_rdata[15:0] = sub_readback;
        end
        else if (hit_ctl)
        begin
            next_rdata[1:0] = control;
        end
    end

    // Registered answer keeps every bus output straight from a flop
    // A fixed single wait state costs one cycle per access but no timing risk
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end
        else if (access)
        begin
            pready_o  <= 1'b1;
            pslverr_o <= bad_access;
            prdata_o  <= (pwrite_i | bad_access) ? 32'h00000000 : next_rdata;
        end
        else
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end
    end

    // ************************************************************
    // Compare match and dead-time outputs
    // ************************************************************
    logic cmp_match;

    // Bit zero of the compare value drops out in high-accuracy mode
    // The match feeds a flop, so the trigger lags the match by one clock
    always_comb
    begin
        cmp_match = ((timer_i.main_count & lsb_mask) == (compare_active & lsb_mask));
    end

    // A/D trigger pulse on a match while counting in a capable mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            adc_trigger_o <= 1'b0;
        end
        else
        begin
            adc_trigger_o <= cmp_match & timer_i.counting & timer_i.timer_run_bit
                           & adc_capable & control[tmr_cmp_dt_pkg::CTL_ADC_SEL_BIT];
        end
    end

    // Dead-time controls for the output stage; zero value means no insertion
    // Insertion needs a non-zero value even where the counter is enabled
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dead_time_o <= '0;
        end
        else
        begin
            dead_time_o.dead_time        <= dead_time;
            dead_time_o.dead_time_run    <= dt_capable & timer_i.timer_run_bit;
            dead_time_o.dead_time_insert <= dt_capable & timer_i.timer_run_bit
                                          & (dead_time != tmr_cmp_dt_pkg::RESET_VALUE);
            dead_time_o.compare_active   <= compare_active;
        end
    end

endmodule // tmr_cmp_dt_regs

// *** dv/tmr_cmp_dt_chk.sv ***
// Concurrent checks on the ports of the compare-five / dead-time register block.
// Assumes it is bound to tmr_cmp_dt_regs and that timer_i is synchronous to clk_i.
`timescale 1ns/1ps
module tmr_cmp_dt_chk
(
    input wire logic                           clk_i,
    input wire logic                           rst_i,
    input wire logic                           psel_i,
    input wire logic                           penable_i,
    input wire logic                           pwrite_i,
    input wire logic [31:0]                    paddr_i,
    input wire logic [31:0]                    pwdata_i,
    input wire logic [3:0]                     pstrb_i,
    input wire logic [31:0]                    prdata_o,
    input wire logic                           pready_o,
    input wire logic                           pslverr_o,
    input wire tmr_cmp_dt_pkg::timer_state_s   timer_i,
    input wire tmr_cmp_dt_pkg::dead_time_out_s dead_time_o,
    input wire logic                           adc_trigger_o
);
    // ************
    // Helpers
    // ************
    tmr_cmp_dt_pkg::timer_state_s p1;
    tmr_cmp_dt_pkg::timer_state_s p2;
    // Timer history: reads are only judged once the inputs have settled
    always_ff @(posedge clk_i)
    begin
        p1 <= timer_i;
        p2 <= p1;
    end
    wire logic take    = psel_i & penable_i & ~pready_o;
    wire logic at_main = paddr_i[31:2] == tmr_cmp_dt_pkg::IDX_MAIN_COUNTER_READBACK[29:0];
    wire logic at_cmp  = paddr_i[31:2] == tmr_cmp_dt_pkg::IDX_COMPARE_VALUE_FIVE[29:0];
    wire logic rd_main = take & ~pwrite_i & at_main;
    wire logic stb     = (timer_i == p1) & (p1 == p2);
    wire logic ha      = timer_i.mode == tmr_cmp_dt_pkg::MODE_HA_TRI_PWM;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ************
    // Assertions
    // ************
    a_ro_refused: assert property (take && pwrite_i && at_main |=> pslverr_o)
        else $error("readback write not refused");
    a_half_refused: assert property (take && pwrite_i && at_cmp && pstrb_i[1:0] != 2'h3 |=> pslverr_o)
        else $error("partial compare write not refused");
    a_dt_field: assert property ((dead_time_o.dead_time & ~tmr_cmp_dt_pkg::DT_FIELD_MASK) == 16'h0)
        else $error("dead-time bits outside field set");
    a_no_insert: assert property (dead_time_o.dead_time == 16'h0 |-> !dead_time_o.dead_time_insert)
        else $error("dead time inserted with zero value");
    a_dt_idle: assert property (!timer_i.timer_run_bit || timer_i.mode < tmr_cmp_dt_pkg::MODE_PWM
        |=> !dead_time_o.dead_time_run)
        else $error("dead-time counter runs outside its modes");
    a_trig_mode: assert property (adc_trigger_o |-> $past(timer_i.mode) inside
        {tmr_cmp_dt_pkg::MODE_HA_TRI_PWM, tmr_cmp_dt_pkg::MODE_DT_PWM,
         tmr_cmp_dt_pkg::MODE_SPECIAL_120, tmr_cmp_dt_pkg::MODE_SPECIAL_PATT})
        else $error("trigger in a mode without selection");
    a_stop_zero: assert property (rd_main && stb && !timer_i.timer_run_bit |=> prdata_o == 32'h0)
        else $error("stopped counter readback not zero");
    a_idle_ones: assert property (rd_main && stb && timer_i.timer_run_bit && !timer_i.counting && !ha
        |=> prdata_o == 32'h0000FFFF)
        else $error("counter readback not all ones before start");
    a_ha_lsb: assert property (rd_main && stb && ha |=> !prdata_o[0])
        else $error("bit zero set in high-accuracy mode");
endmodule // tmr_cmp_dt_chk

bind tmr_cmp_dt_regs tmr_cmp_dt_chk i_tmr_cmp_dt_chk
(
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .timer_i(timer_i), .dead_time_o(dead_time_o), .adc_trigger_o(adc_trigger_o)
);

// *** dv/tb_tmr_cmp_dt_regs.sv ***
// Self-checking bench for the compare-five, dead-time and counter readback registers.
// Assumes an APB slave with one wait state and timer_i sampled at every clock edge.
`timescale 1ns/1ps
module tb_tmr_cmp_dt_regs;
    // ************
    // Signals and model state
    // ************
    localparam logic [31:0] CMP  = tmr_cmp_dt_pkg::IDX_COMPARE_VALUE_FIVE;
    localparam logic [31:0] CMPA = tmr_cmp_dt_pkg::IDX_COMPARE_FIVE_ALIAS;
    localparam logic [31:0] DT   = tmr_cmp_dt_pkg::IDX_DEAD_TIME_VALUE_ZERO;
    localparam logic [31:0] DTA  = tmr_cmp_dt_pkg::IDX_DEAD_TIME_ZERO_ALIAS;
    localparam logic [31:0] MAIN = tmr_cmp_dt_pkg::IDX_MAIN_COUNTER_READBACK;
    localparam logic [31:0] SUB  = tmr_cmp_dt_pkg::IDX_SUB_COUNTER_READBACK;
    localparam logic [31:0] CTL  = tmr_cmp_dt_pkg::IDX_COMPARE_CONTROL;
    logic                           clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, adc_trigger_o, er;
    logic [31:0]                    paddr_i, pwdata_i, prdata_o, rd;
    logic [3:0]                     pstrb_i;
    logic [31:0]                    ids [6] = '{CMP, CMPA, DT, DTA, MAIN, SUB};
    tmr_cmp_dt_pkg::timer_state_s   tmr;
    tmr_cmp_dt_pkg::dead_time_out_s dto;
    int                             n_errors, compares, cyc, seed, v, c, m, k, j, act, dtv, ha, en;

    tmr_cmp_dt_regs i_tmr_cmp_dt_regs
    (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .timer_i(tmr), .dead_time_o(dto), .adc_trigger_o(adc_trigger_o)
    );

    // ************
    // Clock, timeout, verdict and bus tasks
    // ************
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Ceiling sits far above the under one thousand cycles the run needs
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            $display("[ERR] %0t run did not finish before the cycle ceiling", $time);
            conclude();
        end
    end

    task automatic conclude();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One transfer; request held until pready is seen, then an idle edge so no signal is set twice
    task automatic apb(input logic w, input logic [31:0] idx, input logic [31:0] d, input logic [3:0] s);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= {idx[29:0], 2'b00};
        pwdata_i <= d;
        pstrb_i  <= s;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
        end
        while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic all_zero();
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, ids[i], 32'h0, 4'hF);
            chk(rd, 32'h0);
        end
    endtask

    // ************
    // Scenarios
    // ************
    initial
    begin
        seed = 32'hfc79;
        rst_i = 1'b1;
        {psel_i, penable_i, pwrite_i, pstrb_i, paddr_i, pwdata_i} = '0;
        tmr = '0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        all_zero();
        // Aliases share storage; dead-time keeps bits nine to one only
        v = $random(seed);
        apb(1'b1, CMP, v, 4'hF);
        apb(1'b0, CMPA, 32'h0, 4'hF);
        chk(rd, {16'h0, v[15:0]});
        apb(1'b1, DTA, ~v, 4'hF);
        apb(1'b0, DT, 32'h0, 4'hF);
        chk(rd, {16'h0, ~v[15:0] & tmr_cmp_dt_pkg::DT_FIELD_MASK});
        // Refused writes leave state alone
        apb(1'b1, MAIN, v, 4'hF);
        chk(er, 1'b1);
        apb(1'b1, CMP, 32'h0, 4'h1);
        chk(er, 1'b1);
        apb(1'b0, CMPA, 32'h0, 4'hF);
        chk(rd, {16'h0, v[15:0]});
        apb(1'b0, 32'h10, 32'h0, 4'hF);
        chk(er, 1'b1);
        // Write timing per mode; index 12 is high-accuracy with immediate rewrite
        apb(1'b1, DT, 32'h0, 4'hF);
        act = v & 32'hFFFF;
        for (m = 0; m < 13; m++)
        begin
            tmr.mode          <= tmr_cmp_dt_pkg::timer_mode_e'(m == 12 ? 7 : m);
            tmr.timer_run_bit <= 1'b1;
            apb(1'b1, CTL, m == 12, 4'hF);
            v = $random(seed) & 32'hFFFE;
            apb(1'b1, CMP, v, 4'hF);
            @(posedge clk_i);
            if (m < 4 || m == 12)
                act = v;
            chk(dto.compare_active, act);
            tmr.reload_point <= 1'b1;
            @(posedge clk_i);
            tmr.reload_point <= 1'b0;
            repeat (2) @(posedge clk_i);
            chk(dto.compare_active, v);
            act = v;
        end
        // Readbacks and dead-time counter: waiting, counting, then stopped
        for (m = 0; m < 12; m++)
        begin
            c = $random(seed);
            ha = (m == 7);
            en = (m == 4 && c[0]) || (m >= 7 && m <= 10) || (m == 11 && c[0]);
            dtv = en ? c & 32'h03FE : 0;
            apb(1'b1, DT, dtv, 4'hF);
            for (k = 0; k < 3; k++)
            begin
                tmr.mode                 <= tmr_cmp_dt_pkg::timer_mode_e'(m);
                tmr.timer_run_bit        <= k < 2;
                tmr.counting             <= k == 1;
                tmr.dead_time_select_bit <= c[0];
                tmr.main_count           <= c[15:0];
                tmr.sub_count            <= c[31:16];
                repeat (2) @(posedge clk_i);
                apb(1'b0, MAIN, 32'h0, 4'hF);
                chk(rd, k == 2 ? 0 : (k == 0 ? 32'hFFFF : c) & (ha ? 32'hFFFE : 32'hFFFF));
                apb(1'b0, SUB, 32'h0, 4'hF);
                chk(rd, k == 1 && (ha || m == 8) ? (c >> 16) & (ha ? 32'hFFFE : 32'hFFFF) : 0);
                chk(dto.dead_time_run, k < 2 && en);
                chk(dto.dead_time_insert, k < 2 && en && dtv != 0);
                chk(dto.dead_time, dtv);
            end
        end
        // Match trigger per mode, odd compare value against odd and even counts
        apb(1'b1, CTL, 32'h2, 4'hF);
        for (m = 0; m < 12; m++)
        begin
            for (j = 0; j < 2; j++)
            begin
                tmr.timer_run_bit <= 1'b0;
                v = $random(seed) | 1;
                apb(1'b1, CMP, v, 4'hF);
                tmr.mode          <= tmr_cmp_dt_pkg::timer_mode_e'(m);
                tmr.timer_run_bit <= 1'b1;
                tmr.counting      <= 1'b1;
                tmr.main_count    <= (j == 0 || m == 7) ? v[15:0] & 16'hFFFE : v[15:0];
                repeat (2) @(posedge clk_i);
                chk(adc_trigger_o, m == 7 || (j == 1 && (m == 8 || m == 10 || m == 11)));
            end
        end
        apb(1'b1, CTL, 32'h0, 4'hF);
        repeat (2) @(posedge clk_i);
        chk(adc_trigger_o, 1'b0);
        // Reset in mid-run clears the compare, dead-time and readback words; the control word is not read back
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i             <= 1'b0;
        tmr.timer_run_bit <= 1'b0;
        @(posedge clk_i);
        all_zero();
        conclude();
    end
endmodule // tb_tmr_cmp_dt_regs
